/* File: src/amsc_core.sv */
/*
  Mode-control decoder, serial link and result FIFO of a serial ADC.
  Assumes the host is an SPI master sending 16 clocks per frame, sclk idle
  outside frames, and a converter that delivers results on ref_clk.
*/
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------
module amsc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } amsc_fifo_st_t;
  amsc_fifo_st_t q, d;
  logic push, pop;

  assign in_ready_o = q.rdy;
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i && q.rdy;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.rdy = (d.cnt != (AW+1)'(DEPTH));
    if (!resetn_i || clr_i) begin
      d = '0;
      d.rdy = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end
endmodule : amsc_fifo

// ------------------------------------------------------------------
// Top
// ------------------------------------------------------------------
// How it works
// - Two-bit power field, bits 4:3, reset 00, picks power-down in ext mode.
// - Tag bit set in ext mode: 4-bit channel then 12-bit result, MSB first.
// - Internal clock mode always prefixes results with the channel number.
// - Soft-convert bit, internal mode only: convert on chip-select rising edge.
// - Scan code 0000 keeps scan mode and ignores bits 10:7.
// - Scan code 0000 still writes bits 6:3, bit 2 and bit 1.
// - Manual mode: channel named in a frame is returned two frames later.
// - Manual mode uses external clock, one channel per frame, no averaging.
// - Repeat mode converts one channel, storing 4, 8, 12 or 16 results.
// - Repeat mode runs from the internal clock only.
// - Repeat and standard internal modes allow averaging.
// - Standard internal mode scans channel 0 up to N, storing N results.
// - Channel select names the converted, repeated or last scanned channel.
// - A word with MSB zero is a mode control write.
// - Bits 14:11 hold the scan code, reset 0001.
// - Bits 10:7 hold channel select, reset 0000.
module amsc_core #(
  parameter int DEPTH = amsc_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  input wire logic convert_start_pin_i,
  input wire logic res_valid_i,
  output logic res_ready_o,
  input wire amsc_pkg::amsc_result_t res_i,
  input wire logic [1:0] rpt_count_i,
  output logic conv_start_o,
  output logic [3:0] channel_sel_o,
  output logic [3:0] scan_mode_o,
  output logic [1:0] power_sel_o,
  output logic tag_results_o,
  output logic int_clk_o,
  output logic avg_ok_o,
  output logic [4:0] scan_len_o,
  output logic fifo_clr_o
);
  typedef struct packed {
    amsc_pkg::amsc_mode_t mode;
    logic cs_s1, cs_s2, cs_s3;
    logic cnv_s1, cnv_s2, cnv_s3;
    logic wt_s1, wt_s2, wt_s3;
    logic ack_s1, ack_s2;
    logic req;
    logic [15:0] out_word;
    logic conv_start;
    logic fifo_clr;
    logic int_clk;
    logic avg_ok;
    logic [1:0] pwr;
    logic [4:0] scan_len;
  } amsc_ref_t;

  typedef struct packed {
    logic rst_s1, rst_s2;
    logic req_s1, req_s2;
    logic ack;
    logic [3:0] cnt;
    logic [14:0] shin;
    logic [15:0] word;
    logic wtog;
    logic [15:0] shout;
  } amsc_link_t;

  amsc_ref_t q, d;
  amsc_link_t l_q, l_d;
  amsc_pkg::amsc_result_t f_data;
  logic f_valid, f_ready, evt, wr, cs_rise, cnv_rise;
  logic [15:0] w;
  logic [3:0] w_scan;
  logic [1:0] w_rst;

  function automatic logic is_int(input logic [3:0] scan);
    return scan == amsc_pkg::SCAN_REPEAT || scan == amsc_pkg::SCAN_STD_INT;
  endfunction : is_int

  amsc_fifo #(.W(amsc_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .clr_i(q.fifo_clr),
    .in_valid_i(res_valid_i),
    .in_ready_o(res_ready_o),
    .in_data_i(res_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // ----------------------------------------------------------------
  // Reference domain: decode and result hand-off
  // ----------------------------------------------------------------
  assign evt = q.wt_s2 ^ q.wt_s3;
  assign w = l_q.word;  // Stable for a whole frame after the toggle
  assign wr = evt && !w[amsc_pkg::TYPE_BIT];
  assign w_scan = w[amsc_pkg::SCAN_LSB +: 4];
  assign w_rst = w[amsc_pkg::RST_LSB +: 2];
  assign cs_rise = q.cs_s2 && !q.cs_s3;
  assign cnv_rise = q.cnv_s2 && !q.cnv_s3;
  assign f_ready = (q.req == q.ack_s2);

  always_comb begin
    d = q;
    d.cs_s1 = cs_n_i;
    d.cs_s2 = q.cs_s1;
    d.cs_s3 = q.cs_s2;
    d.cnv_s1 = convert_start_pin_i;
    d.cnv_s2 = q.cnv_s1;
    d.cnv_s3 = q.cnv_s2;
    d.wt_s1 = l_q.wtog;
    d.wt_s2 = q.wt_s1;
    d.wt_s3 = q.wt_s2;
    d.ack_s1 = l_q.ack;
    d.ack_s2 = q.ack_s1;
    d.conv_start = 1'b0;
    d.fifo_clr = 1'b0;
    if (wr) begin
      // Null scan code keeps scan and channel
      if (w_scan != amsc_pkg::SCAN_NULL) begin
        d.mode.scan = w_scan;
        d.mode.chan = w[amsc_pkg::CHAN_LSB +: 4];
      end
      // Low fields written unless bits 6:5 ask a full reset; bit 0 never read
      d.mode.pm = w[amsc_pkg::PM_LSB +: 2];
      d.mode.tag = w[amsc_pkg::TAG_BIT];
      d.mode.swc = w[amsc_pkg::SWC_BIT];
      if (w_rst == amsc_pkg::RST_FIFO) begin
        d.fifo_clr = 1'b1;
      end else if (w_rst == amsc_pkg::RST_ALL) begin
        d.mode = amsc_pkg::MODE_RESET;
        d.fifo_clr = 1'b1;
      end
      // One conversion per manual frame, result leaves two frames later
      if (d.mode.scan == amsc_pkg::SCAN_MANUAL &&
          w_rst != amsc_pkg::RST_ALL) begin
        d.conv_start = 1'b1;
      end
    end
    // Decode first so a word and its own chip-select edge work together
    if (cs_rise && is_int(d.mode.scan) && d.mode.swc) begin
      d.conv_start = 1'b1;
      d.mode.swc = 1'b0;  // Host must set it again
    end else if (cnv_rise && is_int(d.mode.scan) && !d.mode.swc) begin
      d.conv_start = 1'b1;
    end
    d.int_clk = is_int(d.mode.scan);
    d.avg_ok = is_int(d.mode.scan);
    d.pwr = d.int_clk ? amsc_pkg::PM_RESET : d.mode.pm;
    if (d.mode.scan == amsc_pkg::SCAN_REPEAT) begin
      d.scan_len = 5'({rpt_count_i, 2'h0}) + 5'h4;
    end else if (d.mode.scan == amsc_pkg::SCAN_STD_INT) begin
      d.scan_len = {1'b0, d.mode.chan};
    end else begin
      d.scan_len = 5'h1;
    end
    if (f_valid && f_ready) begin
      if (q.mode.tag || q.int_clk) begin
        d.out_word = f_data;
      end else begin
        d.out_word = {f_data.data, amsc_pkg::NO_TAG};
      end
      d.req = ~q.req;
    end
    if (!resetn_i) begin
      d = '0;
      d.mode = amsc_pkg::MODE_RESET;
      d.cs_s1 = 1'b1;
      d.cs_s2 = 1'b1;
      d.cs_s3 = 1'b1;
      d.scan_len = 5'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    q <= d;
  end

  assign conv_start_o = q.conv_start;
  assign channel_sel_o = q.mode.chan;
  assign scan_mode_o = q.mode.scan;
  assign power_sel_o = q.pwr;
  assign tag_results_o = q.mode.tag;
  assign int_clk_o = q.int_clk;
  assign avg_ok_o = q.avg_ok;
  assign scan_len_o = q.scan_len;
  assign fifo_clr_o = q.fifo_clr;

  // ----------------------------------------------------------------
  // Link domain: runs on every rising sclk edge, inside a frame or not
  // ----------------------------------------------------------------
  // Request is synchronised on sclk edges, so a result made between
  // frames is armed by one frame and leaves in the one after it
  always_comb begin
    l_d = l_q;
    l_d.rst_s1 = resetn_i;
    l_d.rst_s2 = l_q.rst_s1;
    l_d.req_s1 = q.req;
    l_d.req_s2 = l_q.req_s1;
    l_d.cnt = l_q.cnt + 4'h1;
    l_d.shin = {l_q.shin[13:0], din_i};
    l_d.shout = {l_q.shout[14:0], 1'b0};
    if (l_q.cnt == 4'h0) begin
      // Word held by the request toggle, so safe to sample here
      if (l_q.req_s2 != l_q.ack) begin
        l_d.shout = q.out_word;
        l_d.ack = l_q.req_s2;
      end else begin
        l_d.shout = '0;
      end
    end
    if (l_q.cnt == 4'hF) begin
      l_d.word = {l_q.shin, din_i};
      l_d.wtog = ~l_q.wtog;
    end
    if (!l_q.rst_s2) begin
      l_d = '0;
      l_d.rst_s1 = resetn_i;
      l_d.rst_s2 = l_q.rst_s1;
    end
  end

  always_ff @(posedge sclk_i) begin
    l_q <= l_d;
  end

  assign dout_o = l_q.shout[15];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_mode_wr;
    wr && w_rst != amsc_pkg::RST_ALL;
  endsequence
  sequence s_null_wr;
    s_mode_wr ##0 (w_scan == amsc_pkg::SCAN_NULL);
  endsequence

  property p_pm_store;
    s_mode_wr |=> q.mode.pm == $past(w[4:3]) &&
      power_sel_o == (int_clk_o ? 2'h0 : q.mode.pm);
  endproperty
  a_pm_store: assert property (p_pm_store) else $error("pm wrong");

  property p_tag_ext;
    $changed(q.req) && !$past(q.int_clk) && $past(q.mode.tag) |->
      q.out_word[15:12] == $past(f_data.chan);
  endproperty
  a_tag_ext: assert property (p_tag_ext) else $error("no tag");

  property p_tag_int;
    $changed(q.req) && $past(q.int_clk) |->
      q.out_word == $past(f_data);
  endproperty
  a_tag_int: assert property (p_tag_int) else $error("int untag");

  property p_soft_conv;
    cs_rise && !wr && int_clk_o && q.mode.swc |=>
      conv_start_o && !q.mode.swc;
  endproperty
  a_soft_conv: assert property (p_soft_conv) else $error("swc");

  property p_null_keep;
    s_null_wr |=> $stable(scan_mode_o) && $stable(channel_sel_o);
  endproperty
  a_null_keep: assert property (p_null_keep) else $error("null");

  property p_null_low;
    s_null_wr |=> q.mode.pm == $past(w[4:3]) &&
      tag_results_o == $past(w[2]);
  endproperty
  a_null_low: assert property (p_null_low) else $error("low");

  property p_manual;
    s_mode_wr ##0 (w_scan == amsc_pkg::SCAN_MANUAL) |=>
      conv_start_o && channel_sel_o == $past(w[10:7]) ##1 !conv_start_o;
  endproperty
  a_manual: assert property (p_manual) else $error("manual");

  property p_manual_ext;
    scan_mode_o == amsc_pkg::SCAN_MANUAL |-> !int_clk_o && !avg_ok_o;
  endproperty
  a_manual_ext: assert property (p_manual_ext) else $error("m ext");

  property p_repeat;
    scan_mode_o == amsc_pkg::SCAN_REPEAT |->
      int_clk_o && avg_ok_o && scan_len_o[1:0] == 2'h0 && scan_len_o != '0;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat");

  property p_std;
    scan_mode_o == amsc_pkg::SCAN_STD_INT |->
      avg_ok_o && scan_len_o == {1'b0, channel_sel_o};
  endproperty
  a_std: assert property (p_std) else $error("std");

  property p_read_ignored;
    evt && w[15] |=> $stable(q.mode.scan) && $stable(q.mode.chan) &&
      $stable(q.mode.pm) && $stable(q.mode.tag);
  endproperty
  a_read_ignored: assert property (p_read_ignored) else $error("bit15");

  property p_soft_reset;
    wr && w_rst == amsc_pkg::RST_ALL |=>
      scan_mode_o == 4'h1 && channel_sel_o == 4'h0 && fifo_clr_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("rst");
endmodule : amsc_core

/* File: src/amsc_pkg.sv */
/*
  Shared constants and types for the mode-control decoder of a serial ADC.
  Assumes a 16-bit serial word, MSB first, and 12-bit results.
*/
package amsc_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int RES_W = 12;
  localparam int CH_W = 4;
  localparam int TYPE_BIT = 15;
  localparam int SCAN_LSB = 11;
  localparam int CHAN_LSB = 7;
  localparam int RST_LSB = 5;
  localparam int PM_LSB = 3;
  localparam int TAG_BIT = 2;
  localparam int SWC_BIT = 1;
  localparam int FIFO_DEPTH = 16;
  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SCAN_NULL = 4'h0;
  localparam logic [3:0] SCAN_MANUAL = 4'h1;
  localparam logic [3:0] SCAN_REPEAT = 4'h2;
  localparam logic [3:0] SCAN_STD_INT = 4'h3;
  localparam logic [1:0] RST_FIFO = 2'h1;
  localparam logic [1:0] RST_ALL = 2'h2;
  localparam logic [3:0] SCAN_RESET = 4'h1;
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic [1:0] PM_RESET = 2'h0;
  localparam logic [3:0] NO_TAG = 4'h0;

  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] chan;
    logic [1:0] pm;
    logic tag;
    logic swc;
  } amsc_mode_t;

  localparam amsc_mode_t MODE_RESET = '{scan: SCAN_RESET, chan: CHAN_RESET,
                                        pm: PM_RESET, tag: 1'b0, swc: 1'b0};

  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] data;
  } amsc_result_t;
endpackage : amsc_pkg

/* File: test/amsc_core_tb.sv */
/*
  Self-checking bench of the mode-control decoder.
  Assumes the host model above and a 25 MHz reference clock.
*/
`timescale 1ns/1ns
module amsc_core_tb;
  logic clk, resetn, sclk, cs_n, din, dout, pin, res_valid, res_ready;
  logic conv_start, int_clk, avg_ok, tag, fifo_clr;
  logic [3:0] chan, scan;
  logic [1:0] pm, rpt;
  logic [4:0] len;
  logic [15:0] rx;
  amsc_pkg::amsc_result_t res;
  int n_fail = 0;
  int n_compared = 0;
  int n_conv = 0;
  int n_clr = 0;
  int n0, k;

  amsc_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout));
  amsc_core i_dut (.ref_clk_i(clk), .resetn_i(resetn), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dout_o(dout),
    .convert_start_pin_i(pin), .res_valid_i(res_valid),
    .res_ready_o(res_ready), .res_i(res), .rpt_count_i(rpt),
    .conv_start_o(conv_start), .channel_sel_o(chan), .scan_mode_o(scan),
    .power_sel_o(pm), .tag_results_o(tag), .int_clk_o(int_clk),
    .avg_ok_o(avg_ok), .scan_len_o(len), .fifo_clr_o(fifo_clr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (conv_start === 1'b1) n_conv++;
    if (fifo_clr === 1'b1) n_clr++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wait_ref(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_ref

  task wr(input logic [15:0] w);
    i_host.frame(w, rx);
    wait_ref(8);
  endtask : wr

  task chk_mode(input logic [3:0] s, c, input logic [1:0] p,
                input logic t, ic, input logic [4:0] l);
    chk({12'h000, scan}, {12'h000, s});
    chk({12'h000, chan}, {12'h000, c});
    chk({14'h0000, pm}, {14'h0000, p});
    chk({14'h0000, tag, int_clk}, {14'h0000, t, ic});
    chk({15'h0000, avg_ok}, {15'h0000, ic});
    chk({11'h000, len}, {11'h000, l});
  endtask : chk_mode

  // Valid and data held until the edge that finds ready high
  task push(input logic [3:0] c, input logic [11:0] d);
    int w;
    w = 0;
    res = '{chan: c, data: d};
    res_valid = 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (res_ready !== 1'b1 && w < 50);
    #1 res_valid = 1'b0;
  endtask : push

  task read_frame(input logic [15:0] w, input logic [15:0] exp);
    wait_ref(20);
    // First frame only arms the hand-off and shows zeros
    i_host.frame(w, rx);
    chk(rx, 16'h0000);
    wait_ref(8);
    i_host.frame(w, rx);
    chk(rx, exp);
    wait_ref(8);
  endtask : read_frame

  task end_of_test;
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_manual;
    n0 = n_conv;
    wr(16'h0A95);
    chk_mode(4'h1, 4'h5, 2'h2, 1'b1, 1'b0, 5'h01);
    chk(16'(n_conv - n0), 16'h0001);
    push(4'h5, 12'hABC);
    read_frame(16'h0000, 16'h5ABC);
    chk_mode(4'h1, 4'h5, 2'h0, 1'b0, 1'b0, 5'h01);
    wr(16'h079C);
    chk_mode(4'h1, 4'h5, 2'h3, 1'b1, 1'b0, 5'h01);
  endtask : s_manual

  task s_untagged;
    wr(16'h0A80);
    push(4'h5, 12'h123);
    read_frame(16'hFFFF, 16'h1230);
    chk_mode(4'h1, 4'h5, 2'h0, 1'b0, 1'b0, 5'h01);
  endtask : s_untagged

  task s_repeat;
    for (int r = 0; r < 4; r++) begin
      rpt = 2'(r);
      wr(16'h1198);
      chk_mode(4'h2, 4'h3, 2'h0, 1'b0, 1'b1, 5'(4 * (r + 1)));
    end
  endtask : s_repeat

  task s_std_soft;
    wr(16'h1C80);
    chk_mode(4'h3, 4'h9, 2'h0, 1'b0, 1'b1, 5'h09);
    push(4'h9, 12'h456);
    read_frame(16'h8000, 16'h9456);
    // Own frame's cs rise may already fire it, so count from before
    n0 = n_conv;
    wr(16'h1C82);
    wr(16'h8000);
    chk(16'(n_conv - n0), 16'h0001);
    wr(16'h8000);
    chk(16'(n_conv - n0), 16'h0001);
    pin = 1'b1;
    wait_ref(8);
    pin = 1'b0;
    wait_ref(8);
    chk(16'(n_conv - n0), 16'h0002);
    chk({12'h000, scan}, 16'h0003);
  endtask : s_std_soft

  task s_fifo;
    k = 0;
    while (res_ready === 1'b1 && k < 20) begin
      push(4'(k), 12'h0F0);
      k++;
      wait_ref(1);
    end
    chk(16'(k >= 16 && k <= 17), 16'h0001);
    n0 = n_clr;
    wr(16'h0020);
    chk({15'h0000, res_ready}, 16'h0001);
    chk(16'(n_clr - n0), 16'h0001);
    wr(16'h0040);
    chk(16'(n_clr - n0), 16'h0002);
    chk_mode(4'h1, 4'h0, 2'h0, 1'b0, 1'b0, 5'h01);
  endtask : s_fifo

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    pin = 1'b0;
    res_valid = 1'b0;
    res = '0;
    rpt = 2'h0;
    fork
      wait_ref(10);
      i_host.idle_clocks(4);
    join
    resetn = 1'b1;
    // Link reset synchroniser needs two sclk edges after release
    i_host.idle_clocks(2);
    wait_ref(3);
    chk_mode(4'h1, 4'h0, 2'h0, 1'b0, 1'b0, 5'h01);
    chk({15'h0000, res_ready}, 16'h0001);
    s_manual();
    s_untagged();
    s_repeat();
    s_std_soft();
    s_fifo();
    end_of_test();
  end

  // Whole run is some 21 us; far beyond that means a hang
  initial begin
    #400000;
    n_fail++;
    end_of_test();
  end
endmodule : amsc_core_tb

/* File: test/amsc_host.sv */
/*
  Host model: SPI master that writes mode words and reads result words.
  Assumes sclk idles low, 16 clocks a frame, 32 ns sclk period.
*/
`timescale 1ns/1ns
module amsc_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Edges with no frame, only to clock the link's reset through
  task idle_clocks(input int n);
    repeat (n) begin
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
  endtask : idle_clocks

  // Bit 15 first; bit 15 low makes it a mode write
  task frame(input logic [15:0] w, output logic [15:0] rx);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din_o = w[i];
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
      rx[i] = dout_i;
    end
    #16 cs_n_o = 1'b1;
    // Released line shows no stale level
    din_o = ~din_o;
  endtask : frame
endmodule : amsc_host
